// ==== common/fbs_pkg.sv ====
// Shared constants, carrier structs and state encodings for the fault blink supervisor
package fbs_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_MS = 1000000;
	localparam int MEAS_CYCLE_MS = 1250;
	localparam int MEAS_CLKS = MEAS_CYCLE_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int QUAL_CYCLES = 3;
	localparam int ERR_HYST_MS = 2500;
	localparam int SENSOR_HYST_MS = 5000;
	// Least times round up to whole measurement cycles
	localparam int ERR_HYST_CYC = (ERR_HYST_MS + MEAS_CYCLE_MS - 1) / MEAS_CYCLE_MS;
	localparam int SENSOR_HYST_CYC = (SENSOR_HYST_MS + MEAS_CYCLE_MS - 1) / MEAS_CYCLE_MS;
	localparam int BLINK_ON_MS = 250;
	localparam int BLINK_GAP_MS = 250;
	localparam int BLINK_PAUSE_MS = 1500;
	localparam int BLINK_ON_CLKS = BLINK_ON_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int BLINK_GAP_CLKS = BLINK_GAP_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int BLINK_PAUSE_CLKS = BLINK_PAUSE_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int TICK_W = 27;
	localparam int BLINK_W = 28;

	// ****************************************************************
	// Error vector layout: bit n-1 holds error n
	// ****************************************************************
	localparam int NUM_ERR = 8;
	localparam logic [7:0] FAST_START_MASK = 8'h02;
	localparam logic [7:0] CHG_BLOCK_MASK = 8'he9;
	localparam logic [7:0] DSG_BLOCK_MASK = 8'haa;
	localparam logic [7:0] RELAY_OPEN_MASK = 8'hab;
	localparam logic [7:0] BAL_BLOCK_MASK = 8'h10;
	localparam int ERR_OVERVOLT = 0;
	localparam int ERR_UNDERVOLT = 1;
	localparam int ERR_SPREAD = 2;
	localparam int ERR_SENSOR = 7;
	localparam logic [7:0] RESET_ERR = 8'h00;

	typedef logic [7:0] fbs_errvec_t;

	// Inputs from the measurement front end; fault and safe are sampled on each measurement tick
	typedef struct packed {
		fbs_errvec_t fault;
		fbs_errvec_t safe;
		logic current_low;
		logic bal_cfg;
	} fbs_meas_t;

	// Control outputs towards charger, load, contactor and balancer
	typedef struct packed {
		logic chg_en;
		logic dsg_en;
		logic relay_close;
		logic bal_en;
		logic bal_down;
		logic bal_equal;
		logic soc_force;
	} fbs_ctl_t;

	localparam fbs_ctl_t RESET_CTL = 7'h00;

	typedef enum logic [1:0] {
		B_IDLE,
		B_ON,
		B_GAP,
		B_PAUSE
	} fbs_blink_st_t;

endpackage : fbs_pkg

// ==== rtl/fbs_blink.sv ====
// Red indicator blink sequencer for the active error number
`timescale 1ns/1ps
module fbs_blink #(
	parameter int ON_CLKS = fbs_pkg::BLINK_ON_CLKS,
	parameter int GAP_CLKS = fbs_pkg::BLINK_GAP_CLKS,
	parameter int PAUSE_CLKS = fbs_pkg::BLINK_PAUSE_CLKS
) (
	input logic clk,
	input logic rst,
	input logic ce,
	input logic [3:0] code_in,
	output logic led
);

	typedef struct packed {
		fbs_pkg::fbs_blink_st_t st;
		logic [fbs_pkg::BLINK_W-1:0] cnt;
		logic [3:0] pulses;
		logic [3:0] code;
		logic led;
	} fbs_blink_state_t;

	fbs_blink_state_t st_q;
	fbs_blink_state_t st_d;

	localparam logic [fbs_pkg::BLINK_W-1:0] ON_LAST = fbs_pkg::BLINK_W'(ON_CLKS - 1);
	localparam logic [fbs_pkg::BLINK_W-1:0] GAP_LAST = fbs_pkg::BLINK_W'(GAP_CLKS - 1);
	localparam logic [fbs_pkg::BLINK_W-1:0] PAUSE_LAST = fbs_pkg::BLINK_W'(PAUSE_CLKS - 1);

	// ****************************************************************
	// Burst of ON pulses, then a long dark pause, repeated
	// ****************************************************************
	always_comb begin
		st_d = st_q;
		if (ce) begin
			if (code_in == 4'h0) begin
				st_d.st = fbs_pkg::B_IDLE;
				st_d.cnt = '0;
				st_d.led = 1'b0;
			end else begin
				case (st_q.st)
					fbs_pkg::B_IDLE: begin
						st_d.st = fbs_pkg::B_ON;
						st_d.code = code_in;
						st_d.pulses = 4'h1;
						st_d.cnt = '0;
						st_d.led = 1'b1;
					end
					fbs_pkg::B_ON: begin
						if (st_q.cnt == ON_LAST) begin
							st_d.cnt = '0;
							st_d.led = 1'b0;
							// Last pulse of the burst goes to the long pause
							st_d.st = (st_q.pulses == st_q.code) ? fbs_pkg::B_PAUSE : fbs_pkg::B_GAP;
						end else begin
							st_d.cnt = st_q.cnt + 1'b1;
						end
					end
					fbs_pkg::B_GAP: begin
						if (st_q.cnt == GAP_LAST) begin
							st_d.cnt = '0;
							st_d.led = 1'b1;
							st_d.pulses = st_q.pulses + 4'h1;
							st_d.st = fbs_pkg::B_ON;
						end else begin
							st_d.cnt = st_q.cnt + 1'b1;
						end
					end
					fbs_pkg::B_PAUSE: begin
						if (st_q.cnt == PAUSE_LAST) begin
							st_d.cnt = '0;
							st_d.st = fbs_pkg::B_IDLE;
						end else begin
							st_d.cnt = st_q.cnt + 1'b1;
						end
					end
					default: begin
						st_d.st = fbs_pkg::B_IDLE;
						st_d.led = 1'b0;
					end
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '{st: fbs_pkg::B_IDLE, cnt: '0, pulses: 4'h0, code: 4'h0, led: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign led = st_q.led;

	// ****************************************************************
	// Checks
	// ****************************************************************
	dark_idle_a: assert property (@(posedge clk) disable iff (rst)
		ce && code_in == 4'h0 |=> !led) else $error("indicator lit with no error");
	burst_count_a: assert property (@(posedge clk) disable iff (rst)
		st_q.st != fbs_pkg::B_IDLE |-> st_q.pulses <= st_q.code && st_q.pulses != 4'h0)
		else $error("pulse count beyond error number");
	led_phase_a: assert property (@(posedge clk) disable iff (rst)
		led |-> st_q.st == fbs_pkg::B_ON) else $error("indicator lit outside pulse");
	pause_follow_a: assert property (@(posedge clk) disable iff (rst)
		ce && st_q.st == fbs_pkg::B_ON && st_q.cnt == ON_LAST && st_q.pulses == st_q.code
		&& code_in != 4'h0 |=> st_q.st == fbs_pkg::B_PAUSE && !led)
		else $error("long pause missing after burst");
	burst_cover_c: cover property (@(posedge clk) disable iff (rst)
		st_q.st == fbs_pkg::B_GAP ##1 st_q.st == fbs_pkg::B_ON);

endmodule : fbs_blink

// ==== rtl/fbs_supervisor.sv ====
// Fault qualification, output gating and error indication for the battery unit
//
// Overview of operation
// - The red indicator shows the active error as that many ON pulses and then a longer OFF gap.
// - An error sets only after its condition is seen in 3 consecutive 1.25 s measurement cycles.
// - Error 2 sets on the first measurement after power-on, else normal delay applies.
// - Error 1 sets on cell over-voltage and clears after 2.5 s error hysteresis plus cell hysteresis.
// - Error 1 blocks charging, keeps discharging, opens the relay and balances cells down.
// - Error 2 sets on cell under-voltage, clears with 2.5 s hysteresis, blocks discharge, opens relay.
// - With error 2 and low or positive current the state of charge is forced to 1 %.
// - Error 3 sets on cell spread, balances if enabled and keeps charge, discharge and relay on.
// - Error 4 sets on cell over-temperature, clears after 2.5 s, blocks everything and opens relay.
// - Error 5 sets on unit over-temperature and disables balancing only.
// - Error 6 sets on bad cell count or address, blocks everything and opens the relay.
// - Error 7 sets on low charging temperature and blocks charging only.
// - Error 8 sets on a sensor fault, clears after 5 s, blocks everything and opens the relay.
`timescale 1ns/1ps
module fbs_supervisor #(
	parameter int MEAS_CLKS = fbs_pkg::MEAS_CLKS,
	parameter int BLINK_ON_CLKS = fbs_pkg::BLINK_ON_CLKS,
	parameter int BLINK_GAP_CLKS = fbs_pkg::BLINK_GAP_CLKS,
	parameter int BLINK_PAUSE_CLKS = fbs_pkg::BLINK_PAUSE_CLKS
) (
	input logic MCLK,
	input logic RESET,
	input logic CE,
	input fbs_pkg::fbs_meas_t MEAS,
	output logic MEAS_TICK,
	output fbs_pkg::fbs_ctl_t CTRL,
	output fbs_pkg::fbs_errvec_t ERR_ACTIVE,
	output logic [3:0] ERR_CODE,
	output logic LED_RED
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [fbs_pkg::TICK_W-1:0] tick_cnt;
		logic first;
		logic [7:0][1:0] qual;
		logic [7:0][2:0] rel;
		fbs_pkg::fbs_errvec_t err;
		fbs_pkg::fbs_ctl_t ctl;
		logic [3:0] code;
	} fbs_sup_state_t;

	fbs_sup_state_t st_q;
	fbs_sup_state_t st_d;
	logic tick;

	localparam logic [fbs_pkg::TICK_W-1:0] TICK_LAST = fbs_pkg::TICK_W'(MEAS_CLKS - 1);
	localparam logic [1:0] QUAL_LAST = 2'(fbs_pkg::QUAL_CYCLES - 1);

	// Checks that name no clock use this one
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (RESET);

	// ****************************************************************
	// Decoders
	// ****************************************************************

	// Last release count of the clearing hysteresis for one error
	function automatic logic [2:0] rel_last(input int idx);
		case (idx)
			0, 1, 3: rel_last = 3'(fbs_pkg::ERR_HYST_CYC - 1);
			7: rel_last = 3'(fbs_pkg::SENSOR_HYST_CYC - 1);
			default: rel_last = 3'h0;
		endcase
	endfunction : rel_last

	// Lowest active error number, zero when none
	function automatic logic [3:0] first_err(input fbs_pkg::fbs_errvec_t e);
		first_err = 4'h0;
		for (int k = fbs_pkg::NUM_ERR - 1; k >= 0; k--) begin
			if (e[k]) begin
				first_err = 4'(k + 1);
			end
		end
	endfunction : first_err

	// Most restrictive output combination over all active errors
	function automatic fbs_pkg::fbs_ctl_t ctl_of(input fbs_pkg::fbs_errvec_t e,
		input fbs_pkg::fbs_meas_t m);
		ctl_of.chg_en = ~|(e & fbs_pkg::CHG_BLOCK_MASK);
		ctl_of.dsg_en = ~|(e & fbs_pkg::DSG_BLOCK_MASK);
		ctl_of.relay_close = ~|(e & fbs_pkg::RELAY_OPEN_MASK);
		ctl_of.bal_en = m.bal_cfg & ~|(e & fbs_pkg::BAL_BLOCK_MASK);
		ctl_of.bal_down = e[fbs_pkg::ERR_OVERVOLT] & ~|(e & fbs_pkg::BAL_BLOCK_MASK);
		ctl_of.bal_equal = e[fbs_pkg::ERR_SPREAD] & m.bal_cfg & ~|(e & fbs_pkg::BAL_BLOCK_MASK);
		ctl_of.soc_force = e[fbs_pkg::ERR_UNDERVOLT] & m.current_low;
	endfunction : ctl_of

	// ****************************************************************
	// Measurement cycle timer
	// ****************************************************************
	assign tick = CE && (st_q.tick_cnt == TICK_LAST);

	// ****************************************************************
	// Qualification and release of each error
	// ****************************************************************
	always_comb begin
		st_d = st_q;
		if (CE) begin
			st_d.tick_cnt = tick ? '0 : st_q.tick_cnt + 1'b1;
			if (tick) begin
				st_d.first = 1'b0;
				for (int i = 0; i < fbs_pkg::NUM_ERR; i++) begin
					if (MEAS.fault[i]) begin
						st_d.rel[i] = 3'h0;
						if (!st_q.err[i]) begin
							// Power-on fast set or third consecutive sighting
							if (st_q.qual[i] == QUAL_LAST ||
								(st_q.first && fbs_pkg::FAST_START_MASK[i])) begin
								st_d.err[i] = 1'b1;
								st_d.qual[i] = 2'h0;
							end else begin
								st_d.qual[i] = st_q.qual[i] + 2'h1;
							end
						end
					end else begin
						st_d.qual[i] = 2'h0;
						if (st_q.err[i] && MEAS.safe[i]) begin
							// Clear only after the hysteresis time has run out
							if (st_q.rel[i] == rel_last(i)) begin
								st_d.err[i] = 1'b0;
								st_d.rel[i] = 3'h0;
							end else begin
								st_d.rel[i] = st_q.rel[i] + 3'h1;
							end
						end else begin
							st_d.rel[i] = 3'h0;
						end
					end
				end
			end
			st_d.ctl = ctl_of(st_d.err, MEAS);
			st_d.code = first_err(st_d.err);
		end
	end

	// State register
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			st_q <= '{tick_cnt: '0, first: 1'b1, qual: '0, rel: '0,
				err: fbs_pkg::RESET_ERR, ctl: fbs_pkg::RESET_CTL, code: 4'h0};
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign MEAS_TICK = tick;
	assign CTRL = st_q.ctl;
	assign ERR_ACTIVE = st_q.err;
	assign ERR_CODE = st_q.code;

	// Indicator sequencer
	fbs_blink #(
		.ON_CLKS(BLINK_ON_CLKS),
		.GAP_CLKS(BLINK_GAP_CLKS),
		.PAUSE_CLKS(BLINK_PAUSE_CLKS)
	) fbs_blink_inst (
		.clk(MCLK),
		.rst(RESET),
		.ce(CE),
		.code_in(st_q.code),
		.led(LED_RED)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	third_sight_a: assert property (@(posedge MCLK) disable iff (RESET)
		tick && !st_q.first && !st_q.err[0] && MEAS.fault[0] && st_q.qual[0] == 2'h2
		|=> ERR_ACTIVE[0]) else $error("error 1 not set on third sighting");
	early_set_a: assert property (@(posedge MCLK) disable iff (RESET)
		tick && !st_q.first && !st_q.err[2] && st_q.qual[2] != 2'h2 |=> !ERR_ACTIVE[2])
		else $error("error 3 set before qualification");
	fast_start_a: assert property (@(posedge MCLK) disable iff (RESET)
		tick && st_q.first && MEAS.fault[1] |=> ERR_ACTIVE[1])
		else $error("error 2 missed first measurement");
	ov_release_a: assert property (@(posedge MCLK) disable iff (RESET)
		tick && st_q.err[0] && !MEAS.fault[0] && MEAS.safe[0] && st_q.rel[0] == 3'h0
		|=> ERR_ACTIVE[0]) else $error("error 1 cleared before hysteresis");
	ov_action_a: assert property (@(posedge MCLK) disable iff (RESET)
		ERR_ACTIVE == 8'h01 |-> !CTRL.chg_en && CTRL.dsg_en && !CTRL.relay_close
		&& CTRL.bal_down) else $error("error 1 outputs wrong");
	uv_action_a: assert property (@(posedge MCLK) disable iff (RESET)
		ERR_ACTIVE == 8'h02 |-> CTRL.chg_en && !CTRL.dsg_en && !CTRL.relay_close)
		else $error("error 2 outputs wrong");
	soc_force_a: assert property (@(posedge MCLK) disable iff (RESET)
		CE && st_d.err[1] && MEAS.current_low |=> CTRL.soc_force)
		else $error("charge state not forced");
	spread_action_a: assert property (@(posedge MCLK) disable iff (RESET)
		ERR_ACTIVE == 8'h04 |-> CTRL.chg_en && CTRL.dsg_en && CTRL.relay_close)
		else $error("error 3 outputs wrong");
	hot_cell_a: assert property (@(posedge MCLK) disable iff (RESET)
		ERR_ACTIVE[3] |-> !CTRL.chg_en && !CTRL.dsg_en && !CTRL.relay_close)
		else $error("error 4 outputs wrong");
	hot_unit_a: assert property (@(posedge MCLK) disable iff (RESET)
		ERR_ACTIVE == 8'h10 |-> !CTRL.bal_en && CTRL.chg_en && CTRL.dsg_en
		&& CTRL.relay_close) else $error("error 5 outputs wrong");
	bad_config_a: assert property (@(posedge MCLK) disable iff (RESET)
		ERR_ACTIVE[5] |-> !CTRL.chg_en && !CTRL.dsg_en && !CTRL.relay_close)
		else $error("error 6 outputs wrong");
	cold_charge_a: assert property (@(posedge MCLK) disable iff (RESET)
		ERR_ACTIVE == 8'h40 |-> !CTRL.chg_en && CTRL.dsg_en && CTRL.relay_close)
		else $error("error 7 outputs wrong");
	sensor_hold_a: assert property (@(posedge MCLK) disable iff (RESET)
		tick && st_q.err[7] && !MEAS.fault[7] && st_q.rel[7] == 3'h2
		|=> ERR_ACTIVE[7] && !CTRL.relay_close) else $error("error 8 cleared early");
	worst_wins_a: assert property (@(posedge MCLK) disable iff (RESET)
		ERR_ACTIVE[4] |-> !CTRL.bal_en && !CTRL.bal_down && !CTRL.bal_equal)
		else $error("balancing not blocked");
	code_show_a: assert property (@(posedge MCLK) disable iff (RESET)
		ERR_ACTIVE == 8'h00 |-> ERR_CODE == 4'h0) else $error("code without error");

	// ****************************************************************
	// Release, freeze and output checks
	// ****************************************************************
	// Results move only on a measurement tick
	hold_between_a: assert property (
		!tick |=> $stable(ERR_ACTIVE) && $stable(ERR_CODE))
		else $error("error state moved between ticks");
	// A low enable leaves every register where it was
	freeze_all_a: assert property (
		!CE |=> $stable(st_q) && $stable(LED_RED))
		else $error("state moved while enable low");
	no_error_ctl_a: assert property (
		CE && st_d.err == 8'h00 |=> CTRL.chg_en && CTRL.dsg_en && CTRL.relay_close
		&& !CTRL.bal_down && !CTRL.bal_equal && !CTRL.soc_force)
		else $error("outputs blocked with no error");
	soc_free_a: assert property (
		CE && !st_d.err[1] |=> !CTRL.soc_force)
		else $error("charge state forced without error 2");
	bal_follow_a: assert property (
		CE && !st_d.err[4] |=> CTRL.bal_en == $past(MEAS.bal_cfg))
		else $error("balancing not following configuration");
	equal_bal_a: assert property (
		CE && st_d.err[2] && !st_d.err[4] && MEAS.bal_cfg |=> CTRL.bal_equal)
		else $error("spread not balanced");
	lowest_code_a: assert property (
		ERR_ACTIVE[0] |-> ERR_CODE == 4'h1)
		else $error("error 1 not shown first");
	code_range_a: assert property (
		ERR_ACTIVE != 8'h00 |-> ERR_CODE != 4'h0 && ERR_CODE <= 4'h8
		&& ERR_ACTIVE[3'(ERR_CODE - 4'h1)]) else $error("code names no active error");
	uv_release_a: assert property (
		tick && st_q.err[1] && !MEAS.fault[1] && MEAS.safe[1] && st_q.rel[1] == 3'h1
		|=> !ERR_ACTIVE[1]) else $error("error 2 held past hysteresis");
	hot_release_a: assert property (
		tick && st_q.err[3] && !MEAS.fault[3] && MEAS.safe[3] && st_q.rel[3] == 3'h0
		|=> ERR_ACTIVE[3]) else $error("error 4 cleared before hysteresis");
	sensor_clear_a: assert property (
		tick && st_q.err[7] && !MEAS.fault[7] && MEAS.safe[7] && st_q.rel[7] == 3'h3
		|=> !ERR_ACTIVE[7]) else $error("error 8 held past hysteresis");
	unsafe_hold_a: assert property (
		tick && st_q.err[0] && !MEAS.safe[0] |=> ERR_ACTIVE[0])
		else $error("error 1 cleared outside cell hysteresis");
	spread_release_a: assert property (
		tick && st_q.err[2] && !MEAS.fault[2] && MEAS.safe[2] |=> !ERR_ACTIVE[2])
		else $error("error 3 held past hysteresis");
	unit_release_a: assert property (
		tick && st_q.err[4] && !MEAS.fault[4] && MEAS.safe[4] |=> !ERR_ACTIVE[4])
		else $error("error 5 held past hysteresis");
	config_release_a: assert property (
		tick && st_q.err[5] && !MEAS.fault[5] && MEAS.safe[5] |=> !ERR_ACTIVE[5])
		else $error("error 6 held after fix");
	cold_release_a: assert property (
		tick && st_q.err[6] && !MEAS.fault[6] && MEAS.safe[6] |=> !ERR_ACTIVE[6])
		else $error("error 7 held past hysteresis");
	tick_pulse_a: assert property (
		MEAS_TICK |=> !MEAS_TICK)
		else $error("measurement tick wider than one cycle");
	fast_end_a: assert property (
		tick |=> !st_q.first)
		else $error("power-on fast set outlived first tick");

	// Checks shared by every error bit
	for (genvar g = 0; g < fbs_pkg::NUM_ERR; g++) begin : g_err_chk
		set_wins_a: assert property (
			tick && MEAS.fault[g] && st_q.err[g] |=> ERR_ACTIVE[g])
			else $error("error cleared while its fault stands");
		no_cause_a: assert property (
			tick && !MEAS.fault[g] && !st_q.err[g] |=> !ERR_ACTIVE[g])
			else $error("error set without its fault");
		qual_reset_a: assert property (
			tick && !MEAS.fault[g] |=> st_q.qual[g] == 2'h0)
			else $error("sighting count kept over a clean cycle");
	end

	ov_set_c: cover property (@(posedge MCLK) disable iff (RESET)
		!ERR_ACTIVE[0] ##1 ERR_ACTIVE[0]);
	fast_uv_c: cover property (@(posedge MCLK) disable iff (RESET)
		tick && st_q.first && MEAS.fault[1]);
	sensor_clr_c: cover property (@(posedge MCLK) disable iff (RESET)
		ERR_ACTIVE[7] ##1 !ERR_ACTIVE[7]);
	multi_err_c: cover property (@(posedge MCLK) disable iff (RESET)
		ERR_ACTIVE[0] && ERR_ACTIVE[1]);

endmodule : fbs_supervisor

// ==== verif/fbs_frontend_model.sv ====
// Behavioural measurement front end that feeds the supervisor
`timescale 1ns/1ps
module fbs_frontend_model (
	input wire logic [7:0] fault_req,
	input wire logic [7:0] safe_req,
	input wire logic cur_low_req,
	input wire logic bal_cfg_req,
	output fbs_pkg::fbs_meas_t meas
);
	// ****************************************************************
	// Condition reporting
	// ****************************************************************
	// A condition still detected is never reported as inside its hysteresis
	assign meas = '{fault: fault_req, safe: safe_req & ~fault_req,
		current_low: cur_low_req, bal_cfg: bal_cfg_req};
endmodule : fbs_frontend_model

// ==== verif/tb_fault_blink_supervisor.sv ====
// Self-checking bench for the fault blink supervisor
`timescale 1ns/1ps
module tb_fault_blink_supervisor;
	localparam int MC = 20;
	localparam int ON = 2;
	localparam int GAP = 2;
	localparam int PAUSE = 6;
	logic MCLK = 1'b0;
	logic RESET = 1'b1;
	logic CE = 1'b1;
	logic [7:0] fault_r = 8'h00;
	logic [7:0] safe_r = 8'h00;
	logic cur_r = 1'b0;
	logic bal_r = 1'b0;
	fbs_pkg::fbs_meas_t MEAS;
	logic MEAS_TICK;
	fbs_pkg::fbs_ctl_t CTRL;
	fbs_pkg::fbs_errvec_t ERR_ACTIVE;
	logic [3:0] ERR_CODE;
	logic LED_RED;
	int miscompares = 0;
	int compares = 0;
	int qual [8];
	int rel [8];
	int need [8] = '{2, 2, 1, 2, 1, 1, 1, 4};
	logic [7:0] m_err = 8'h00;
	logic m_first = 1'b1;

	// ****************************************************************
	// Clock, front end and design
	// ****************************************************************
	always #5 MCLK = ~MCLK;
	fbs_frontend_model fbs_frontend_model_inst (.fault_req(fault_r), .safe_req(safe_r),
		.cur_low_req(cur_r), .bal_cfg_req(bal_r), .meas(MEAS));
	fbs_supervisor #(.MEAS_CLKS(MC), .BLINK_ON_CLKS(ON), .BLINK_GAP_CLKS(GAP),
		.BLINK_PAUSE_CLKS(PAUSE)) fbs_supervisor_inst (.MCLK(MCLK), .RESET(RESET), .CE(CE),
		.MEAS(MEAS), .MEAS_TICK(MEAS_TICK), .CTRL(CTRL), .ERR_ACTIVE(ERR_ACTIVE),
		.ERR_CODE(ERR_CODE), .LED_RED(LED_RED));

	// ****************************************************************
	// Reference model of error qualification and release
	// ****************************************************************
	always @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			m_err = 8'h00;
			m_first = 1'b1;
			foreach (qual[i]) begin
				qual[i] = 0;
				rel[i] = 0;
			end
		end else if (MEAS_TICK === 1'b1) begin
			for (int i = 0; i < 8; i++) begin
				if (MEAS.fault[i]) begin
					qual[i]++;
					rel[i] = 0;
					if (qual[i] >= 3 || (i == 1 && m_first)) m_err[i] = 1'b1;
				end else begin
					qual[i] = 0;
					rel[i] = (m_err[i] && MEAS.safe[i]) ? rel[i] + 1 : 0;
					if (rel[i] >= need[i]) m_err[i] = 1'b0;
				end
			end
			m_first = 1'b0;
		end
	end

	// Expected control outputs from the active errors
	function automatic fbs_pkg::fbs_ctl_t exp_ctl(logic [7:0] e, logic cl, logic bc);
		fbs_pkg::fbs_ctl_t c;
		c.chg_en = ~|(e & 8'he9);
		c.dsg_en = ~|(e & 8'haa);
		c.relay_close = ~|(e & 8'hab);
		c.bal_en = bc & ~e[4];
		c.bal_down = e[0] & ~e[4];
		c.bal_equal = e[2] & bc & ~e[4];
		c.soc_force = e[1] & cl;
		return c;
	endfunction : exp_ctl

	// Lowest active error number, zero when none
	function automatic logic [3:0] exp_code(logic [7:0] e);
		for (int i = 0; i < 8; i++) begin
			if (e[i]) return 4'(i + 1);
		end
		return 4'h0;
	endfunction : exp_code

	// ****************************************************************
	// Checking tasks
	// ****************************************************************
	task automatic check(string what, logic [31:0] got, logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic drive(logic [7:0] f, logic [7:0] s, logic c, logic b);
		fault_r = f;
		safe_r = s;
		cur_r = c;
		bal_r = b;
	endtask : drive

	// Wait for a measurement tick, then compare errors, code and control outputs
	task automatic next_tick();
		int n;
		n = 0;
		do begin
			@(negedge MCLK);
			n++;
		end while (MEAS_TICK !== 1'b1 && n < 2 * MC);
		check("tick", MEAS_TICK, 1'b1);
		@(posedge MCLK);
		#1;
		check("err", ERR_ACTIVE, m_err);
		check("code", ERR_CODE, exp_code(m_err));
		check("ctl", CTRL, exp_ctl(m_err, cur_r, bal_r));
	endtask : next_tick

	// Measure one whole burst after a pause
	task automatic blink(int n);
		int lo;
		int hi;
		int cnt;
		int ph;
		lo = 0;
		hi = 0;
		cnt = 0;
		ph = 0;
		for (int k = 0; k < 600 && ph < 4; k++) begin
			@(posedge MCLK);
			#1;
			if (LED_RED === 1'b1) begin
				if (lo > 0 && ph == 3) begin
					check("pause", lo, PAUSE + 1);
					ph = 4;
				end else if (lo > 0 && ph >= 1) begin
					if (ph == 2) check("gap", lo, GAP);
					cnt++;
					ph = 2;
				end
				lo = 0;
				hi++;
			end else begin
				if (hi > 0 && ph == 2) check("on", hi, ON);
				hi = 0;
				lo++;
				if (lo > GAP && ph != 2 && ph < 3) ph = 1;
				if (lo > GAP && ph == 2) ph = 3;
			end
		end
		check("pulses", cnt, n);
		check("burst end", ph, 4);
	endtask : blink

	// Indicator stays dark and ticks stop as asked
	task automatic quiet(string what, logic [31:0] exp_ticks);
		int lit;
		int ticks;
		lit = 0;
		ticks = 0;
		for (int k = 0; k < 3 * MC; k++) begin
			@(posedge MCLK);
			#1;
			if (LED_RED !== 1'b0) lit++;
			if (MEAS_TICK === 1'b1) ticks++;
		end
		check(what, lit, 0);
		if (exp_ticks == 0) check("frozen", ticks, 0);
	endtask : quiet

	task automatic final_report();
		$display("Compares %0d, miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		void'($urandom(32'h64cac9ab));
		drive(8'h03, 8'h00, 1'b1, 1'b1);
		repeat (3) @(posedge MCLK);
		#1;
		check("reset ctl", CTRL, 7'h00);
		check("reset err", {ERR_ACTIVE, LED_RED}, 9'h000);
		RESET = 1'b0;
		next_tick();
		drive(8'h00, 8'hff, 1'b1, 1'b1);
		repeat (3) next_tick();
		for (int n = 1; n <= 8; n++) begin
			drive(8'h01 << (n - 1), 8'h00, n[0], n[1]);
			repeat (3) next_tick();
			blink(n);
			drive(8'h00, 8'hff, n[0], n[1]);
			repeat (5) next_tick();
			quiet("dark", 1);
		end
		// Second reset: only error 2 gets the fast set, then freeze with error 1 pending
		drive(8'h03, 8'h00, 1'b0, 1'b1);
		RESET = 1'b1;
		repeat (3) @(posedge MCLK);
		#1;
		RESET = 1'b0;
		next_tick();
		CE = 1'b0;
		quiet("ce dark", 0);
		CE = 1'b1;
		for (int t = 0; t < 60; t++) begin
			drive($urandom & $urandom, $urandom, $urandom, $urandom);
			next_tick();
		end
		final_report();
	end

	// Cut a hang short
	initial begin
		#500000;
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		final_report();
	end
endmodule : tb_fault_blink_supervisor
